/* rtl/csfc_top.sv */
// Clock synth holding, shadow, unlock key, status and clock switch control
//
// How it works
// - Control writes update only the holding copy until unlock completes.
// - Config writes update only the holding copy until unlock completes.
// - Completed unlock without power down copies both holding registers into shadow registers.
// - Status reads return shadow settings and lock state.
// - Effective enable bit turns the loop on to lock.
// - Loop clock selected only when effective connect and enable are set.
// - Connect without enable acts as both clear.
// - Config: multiplier bits 4:0, divider bits 6:5, bit 7 reserved.
// - Status: multiplier 4:0, divider 6:5, enable 8, connect 9, lock 10.
// - Power down clears effective enable and connect.
// - Lock bit reads one only when loop is locked.
// - Lock bit drives an interrupt request.
// - Clock source change is glitch free in both directions.
// - No interlock on connect, no auto-disconnect on lock loss.
// - After reset loop off, bypassed, registers cleared.
// - Multiplier is an integer 1 to 32.
// - Output divider 2, 4, 8 or 16, fifty percent duty.
// - Unlock is 0xaa then 0x55 in consecutive bus cycles.
// - Divider code 00..11 means P of 1, 2, 4, 8.
// - Multiplier field holds M minus one.
`timescale 1ns/1ps
`include "csfc_params.svh"
module csfc_top
	import csfc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register access port
	input wire logic bus_sel,
	input wire logic bus_write,
	input wire logic [`CSFC_ADDR_W-1:0] bus_addr,
	input wire csfc_pkg::csfc_byte_t bus_wdata,
	output logic [15:0] bus_rdata,
	// Power control
	input wire logic power_down,
	// Analog loop
	input wire logic loop_locked_async,
	output logic loop_power_on,
	output csfc_pkg::csfc_msel_t loop_multiplier,
	output csfc_pkg::csfc_psel_t loop_divider,
	// Clock switch gates, loop clock domain handled in the switch cell
	output logic gate_osc_clk,
	output logic gate_loop_clk,
	output logic loop_clk_selected,
	// Interrupt request
	output logic lock_irq
);
	import csfc_pkg::*;

	// Holding, shadow and key state
	csfc_byte_t ctrl_hold_r;
	csfc_byte_t cfg_hold_r;
	logic enable_r;
	logic connect_r;
	csfc_msel_t msel_r;
	csfc_psel_t psel_r;
	csfc_key_e key_r;
	logic lock_meta_r;
	logic lock_sync_r;
	csfc_sw_e sw_r;
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_key;
	logic key_done;
	logic want_loop;
	// Decoded bus cycles and read path
	logic bus_rd;
	logic key_first;
	logic key_second;
	csfc_half_t status_word;
	csfc_half_t rd_word;
	csfc_half_t rdata_r;

	// ****************************************
	// Bus decode
	// ****************************************
	assign wr_ctrl = bus_sel && bus_write && bus_addr == `CSFC_OFS_CTRL;
	assign wr_cfg = bus_sel && bus_write && bus_addr == `CSFC_OFS_CFG;
	assign wr_key = bus_sel && bus_write && bus_addr == `CSFC_OFS_KEY;
	assign bus_rd = bus_sel && !bus_write;
	assign key_first = wr_key && bus_wdata == `CSFC_KEY_FIRST;
	assign key_second = wr_key && bus_wdata == `CSFC_KEY_SECOND;

	// ****************************************
	// Holding registers
	// ****************************************
	// Control copy, reserved bits 7:2 read back zero
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ctrl_hold_r <= `CSFC_RESET_VAL;
		else if (wr_ctrl)
			ctrl_hold_r <= bus_wdata & `CSFC_CTRL_MASK;
	end

	// Config copy, reserved bit 7 reads back zero
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg_hold_r <= `CSFC_RESET_VAL;
		else if (wr_cfg)
			cfg_hold_r <= bus_wdata & `CSFC_CFG_MASK;
	end

	// ****************************************
	// Unlock key sequence
	// ****************************************
	// Any bus cycle other than a 0xaa key write breaks the pair; a repeated first key write keeps it armed
	// Idle cycles between the keys keep the pair armed
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			key_r <= CSFC_KEY_IDLE;
		else if (key_first)
			key_r <= CSFC_KEY_ARMED;
		else if (bus_sel)
			key_r <= CSFC_KEY_IDLE;
	end

	assign key_done = key_second && key_r == CSFC_KEY_ARMED;

	// ****************************************
	// Shadow registers
	// ****************************************
	// Enable and connect; power down wins over a feed in the same cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			enable_r <= 1'b0;
			connect_r <= 1'b0;
		end
		else if (power_down)
		begin
			enable_r <= 1'b0;
			connect_r <= 1'b0;
		end
		else if (key_done)
		begin
			enable_r <= ctrl_hold_r[`CSFC_BIT_ENABLE];
			connect_r <= ctrl_hold_r[`CSFC_BIT_CONNECT];
		end
	end

	// Multiplier and divider keep their value through power down
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			msel_r <= '0;
			psel_r <= '0;
		end
		else if (key_done && !power_down)
		begin
			msel_r <= cfg_hold_r[`CSFC_MSEL_HI:`CSFC_MSEL_LO];
			psel_r <= cfg_hold_r[`CSFC_PSEL_HI:`CSFC_PSEL_LO];
		end
	end

	// ****************************************
	// Loop drive
	// ****************************************
	// Loop takes M-1 and P codes directly; it applies M and 2*P
	assign loop_power_on = enable_r;
	assign loop_multiplier = msel_r;
	assign loop_divider = psel_r;

	// ****************************************
	// Lock synchroniser
	// ****************************************
	// Only the second flop feeds status and interrupt
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lock_meta_r <= 1'b0;
			lock_sync_r <= 1'b0;
		end
		else
		begin
			lock_meta_r <= loop_locked_async;
			lock_sync_r <= lock_meta_r;
		end
	end

	// ****************************************
	// Lock interrupt
	// ****************************************
	assign lock_irq = lock_sync_r;

	// ****************************************
	// Glitch-free clock switch control
	// ****************************************
	// Connect does not wait for lock and lock loss does not disconnect
	assign want_loop = enable_r && connect_r;

	// Break before make: both gates off for one cycle between sources
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			sw_r <= CSFC_SW_OSC;
		else
		begin
			unique case (sw_r)
				CSFC_SW_OSC:
				begin
					if (want_loop)
						sw_r <= CSFC_SW_OFF_TO_LOOP;
				end
				CSFC_SW_OFF_TO_LOOP:
				begin
					if (want_loop)
						sw_r <= CSFC_SW_LOOP;
					else
						sw_r <= CSFC_SW_OSC;
				end
				CSFC_SW_LOOP:
				begin
					if (!want_loop)
						sw_r <= CSFC_SW_OFF_TO_OSC;
				end
				CSFC_SW_OFF_TO_OSC:
				begin
					if (want_loop)
						sw_r <= CSFC_SW_LOOP;
					else
						sw_r <= CSFC_SW_OSC;
				end
			endcase
		end
	end

	// Both gates low in the dead cycles
	always_comb
	begin
		gate_osc_clk = 1'b0;
		gate_loop_clk = 1'b0;
		unique case (sw_r)
			CSFC_SW_OSC:
				gate_osc_clk = 1'b1;
			CSFC_SW_LOOP:
				gate_loop_clk = 1'b1;
			CSFC_SW_OFF_TO_LOOP, CSFC_SW_OFF_TO_OSC:
			begin
				gate_osc_clk = 1'b0;
				gate_loop_clk = 1'b0;
			end
		endcase
	end

	assign loop_clk_selected = gate_loop_clk;

	// ****************************************
	// Status word
	// ****************************************
	// Reserved status bits read zero
	always_comb
	begin
		status_word = '0;
		status_word[`CSFC_MSEL_HI:`CSFC_MSEL_LO] = msel_r;
		status_word[`CSFC_PSEL_HI:`CSFC_PSEL_LO] = psel_r;
		status_word[`CSFC_STAT_ENABLE] = enable_r;
		status_word[`CSFC_STAT_CONNECT] = connect_r;
		status_word[`CSFC_STAT_LOCK] = lock_sync_r;
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Holding registers read back as written, reserved bits zero
	always_comb
	begin
		rd_word = '0;
		if (bus_rd)
		begin
			unique case (bus_addr)
				`CSFC_OFS_CTRL:
					rd_word[7:0] = ctrl_hold_r;
				`CSFC_OFS_CFG:
					rd_word[7:0] = cfg_hold_r;
				`CSFC_OFS_STAT:
					rd_word = status_word;
				default:
					rd_word = '0;
			endcase
		end
	end

	// ****************************************
	// Read data register
	// ****************************************
	// Captured on the read cycle, held until the next read
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_r <= '0;
		else if (bus_rd)
			rdata_r <= rd_word;
	end

	assign bus_rdata = rdata_r;
endmodule // csfc_top

/* include/csfc_params.svh */
// Register offsets, field positions and constants of the clock synth control
`ifndef CSFC_PARAMS_SVH
`define CSFC_PARAMS_SVH
`define CSFC_ADDR_W 32
`define CSFC_OFS_CTRL 32'he01fc080
`define CSFC_OFS_CFG 32'he01fc084
`define CSFC_OFS_STAT 32'he01fc088
`define CSFC_OFS_KEY 32'he01fc08c
`define CSFC_KEY_FIRST 8'haa
`define CSFC_KEY_SECOND 8'h55
`define CSFC_BIT_ENABLE 0
`define CSFC_BIT_CONNECT 1
`define CSFC_MSEL_HI 4
`define CSFC_MSEL_LO 0
`define CSFC_PSEL_HI 6
`define CSFC_PSEL_LO 5
`define CSFC_STAT_ENABLE 8
`define CSFC_STAT_CONNECT 9
`define CSFC_STAT_LOCK 10
`define CSFC_CTRL_MASK 8'h03
`define CSFC_CFG_MASK 8'h7f
`define CSFC_RESET_VAL 8'h00
`endif

/* include/csfc_pkg.sv */
// Types of the clock synth control
package csfc_pkg;
	typedef logic [7:0] csfc_byte_t;
	typedef logic [15:0] csfc_half_t;
	typedef logic [4:0] csfc_msel_t;
	typedef logic [1:0] csfc_psel_t;
	typedef enum logic [1:0] {CSFC_KEY_IDLE, CSFC_KEY_ARMED} csfc_key_e;
	typedef enum logic [1:0] {CSFC_SW_OSC, CSFC_SW_OFF_TO_LOOP, CSFC_SW_LOOP,
		CSFC_SW_OFF_TO_OSC} csfc_sw_e;
endpackage

/* testbench/csfc_chk.sv */
// Port checker for the clock synth control
`timescale 1ns/1ps
`include "csfc_params.svh"
module csfc_chk
	import csfc_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk,
	input wire logic reset_n,
	input wire logic bus_sel,
	input wire logic bus_write,
	input wire logic [31:0] bus_addr,
	input wire csfc_pkg::csfc_byte_t bus_wdata,
	input wire logic [15:0] bus_rdata,
	// Loop side
	input wire logic power_down,
	input wire logic loop_locked_async,
	input wire logic loop_power_on,
	input wire csfc_pkg::csfc_msel_t loop_multiplier,
	input wire logic gate_osc_clk,
	input wire logic gate_loop_clk,
	input wire logic loop_clk_selected,
	input wire logic lock_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd_st = bus_sel && !bus_write && bus_addr == `CSFC_OFS_STAT;
	wire key_ok = bus_sel && bus_write && bus_addr == `CSFC_OFS_KEY
		&& bus_wdata == 8'h55;
	a_lock_sync: assert property ($past(reset_n, 2) |->
		lock_irq == $past(loop_locked_async, 2)) else $error("lock late");
	a_status_read: assert property (rd_st |=>
		bus_rdata[10] == $past(lock_irq)
		&& bus_rdata[8] == $past(loop_power_on)
		&& bus_rdata[4:0] == $past(loop_multiplier)) else $error("status bad");
	a_gates_apart: assert property (!(gate_osc_clk && gate_loop_clk))
		else $error("both gates on");
	a_sel_mirror: assert property (loop_clk_selected == gate_loop_clk)
		else $error("select bad");
	a_power_off: assert property (power_down |=> !loop_power_on)
		else $error("power down ignored");
	a_loop_dead: assert property ($rose(gate_loop_clk) |->
		!$past(gate_osc_clk) && $past(loop_power_on)) else $error("loop gate");
	a_osc_dead: assert property ($rose(gate_osc_clk) |->
		!$past(gate_loop_clk)) else $error("osc gate");
	a_mult_shadow: assert property ($changed(loop_multiplier) |->
		$past(key_ok)) else $error("multiplier moved");
	a_enable_shadow: assert property ($rose(loop_power_on) |->
		$past(key_ok) && !$past(power_down)) else $error("enable moved");
endmodule // csfc_chk
bind csfc_top csfc_chk i_chk (.*);

/* testbench/tb_csfc_top.sv */
// Testbench for the clock synth control
`timescale 1ns/1ps
`include "csfc_params.svh"
module tb_csfc_top;
	import csfc_pkg::*;
	logic clk, reset_n, bus_sel, bus_write, power_down, loop_locked_async;
	logic [31:0] bus_addr;
	csfc_byte_t bus_wdata;
	logic [15:0] bus_rdata;
	csfc_msel_t loop_multiplier;
	csfc_psel_t loop_divider;
	logic loop_power_on, gate_osc_clk, gate_loop_clk;
	logic loop_clk_selected, lock_irq;
	int mismatches, compares;
	csfc_top i_dut (.*);
	// ****
	// Bus tasks
	// ****
	task automatic chk(input logic [15:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input csfc_byte_t d);
		bus_sel <= 1'h1;
		bus_write <= 1'h1;
		bus_addr <= a;
		bus_wdata <= d;
		@(negedge clk);
		@(posedge clk);
	endtask
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		bus_sel <= 1'h1;
		bus_write <= 1'h0;
		bus_addr <= a;
		@(negedge clk);
		@(posedge clk);
		bus_sel <= 1'h0;
		@(negedge clk);
		chk(bus_rdata, exp);
		@(posedge clk);
	endtask
	task automatic rs(input logic [15:0] exp);
		rd(`CSFC_OFS_STAT, exp);
	endtask
	task automatic idle(input int n);
		bus_sel <= 1'h0;
		repeat (n) @(posedge clk);
	endtask
	task automatic feed;
		wr(`CSFC_OFS_KEY, 8'haa);
		wr(`CSFC_OFS_KEY, 8'h55);
		idle(3);
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (500) @(posedge clk);
		mismatches++;
		end_sim();
	end
	// ****
	// Tests
	// ****
	initial
	begin
		reset_n = 1'h0;
		bus_sel = 1'h0;
		bus_write = 1'h0;
		bus_addr = 32'h0;
		bus_wdata = 8'h00;
		power_down = 1'h0;
		loop_locked_async = 1'h0;
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		rs(16'h0000);
		wr(`CSFC_OFS_CTRL, 8'h01);
		wr(`CSFC_OFS_CFG, 8'h25);
		rd(`CSFC_OFS_CTRL, 16'h0001);
		rd(`CSFC_OFS_CFG, 16'h0025);
		rs(16'h0000);
		wr(`CSFC_OFS_KEY, 8'hab);
		wr(`CSFC_OFS_KEY, 8'h55);
		wr(`CSFC_OFS_KEY, 8'haa);
		rs(16'h0000);
		wr(`CSFC_OFS_KEY, 8'h55);
		rs(16'h0000);
		feed();
		rs(16'h0125);
		loop_locked_async <= 1'h1;
		idle(3);
		rs(16'h0525);
		chk(lock_irq, 1'h1);
		wr(`CSFC_OFS_CTRL, 8'h03);
		feed();
		chk(gate_loop_clk, 1'h1);
		loop_locked_async <= 1'h0;
		idle(3);
		chk(gate_loop_clk, 1'h1);
		rs(16'h0325);
		wr(`CSFC_OFS_CTRL, 8'h02);
		feed();
		chk(gate_osc_clk, 1'h1);
		rs(16'h0225);
		wr(`CSFC_OFS_CTRL, 8'h03);
		feed();
		power_down <= 1'h1;
		idle(3);
		rs(16'h0025);
		chk(gate_osc_clk, 1'h1);
		power_down <= 1'h0;
		wr(`CSFC_OFS_CFG, 8'h7f);
		feed();
		chk({loop_divider, loop_multiplier}, 16'h007f);
		end_sim();
	end
endmodule // tb_csfc_top
